// ==== logic/mrsr_bank.sv ====
// Monitor readout bank: reading registers with freeze, hot timer and first event flags
`timescale 1ns/1ps
// Contract
// [R01] Onchip temp two LSBs in extra bits 1:0
// [R02] Extra bits register bits 7:2 read zero
// [R03] Host reads extension register before MSB registers
// [R04] Voltage group frozen until every MSB read
// [R05] Temperature group frozen until MSBs read
// [R06] Analog one, two, supply MSBs at 0A-0C
// [R07] Far and onchip temp MSBs, reset zero
// [R08] Timer bit0 sets on overheat, clears on read
// [R09] Timer bits 7:1 zero below 45.52 ms
// [R10] Long assertion: 8-bit count, 22.76 ms steps
// [R11] Flag bit0: second cooler slow, drive on
// [R12] Flag bit1: first cooler slow, drive on
// [R13] Flag bit2: onchip temp out of limits
// [R14] Flag bit3: far temp out of limits
// [R15] Flag bits 4-6: supply, analog two, one
// [R16] Read clears limit bit only if fault gone
// [R17] Flag bit7 is OR of second status
// [R18] First extension register holds four LSB pairs
// [R19] Readings are ten bits: MSB plus pair
module mrsr_bank #(
  parameter int HOT_TICK_CYCLES = mrsr_pkg::MRSR_TICK_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_rd_en,
  input wire logic [7:0] i_rd_addr,
  output logic [7:0] o_rd_data,
  output logic o_rd_valid,
  input wire logic i_result_valid,
  input wire logic [9:0] i_analog_input_one,
  input wire logic [9:0] i_analog_input_two,
  input wire logic [9:0] i_supply_result,
  input wire logic [9:0] i_far_sensor_one_result,
  input wire logic [9:0] i_onchip_temp_result,
  input wire logic i_overheat_pin_n,
  input wire logic i_first_cooler_slow,
  input wire logic i_second_cooler_slow,
  input wire logic i_first_cooler_output_on,
  input wire logic i_second_cooler_output_on,
  input wire logic i_onchip_temp_fault,
  input wire logic i_far_sensor_one_fault,
  input wire logic i_supply_fault,
  input wire logic i_analog_two_fault,
  input wire logic i_analog_one_fault,
  input wire logic [7:0] i_second_status
);
  import mrsr_pkg::*;

  mrsr_bank_state_t q;
  mrsr_bank_state_t d;
  logic [MRSR_NUM_CH-1:0][9:0] new_result;
  logic [6:0] events;
  logic [6:0] clear_mask;
  logic [7:0] timer_value;
  logic hot;
  logic rd_ext_one;
  logic rd_ext_two;
  logic rd_flags;
  logic rd_timer;
  logic second_status_summary;

  // Ten-bit results from the converter, one slot per channel
  assign new_result[MRSR_CH_ANALOG_ONE] = i_analog_input_one; // R19
  assign new_result[MRSR_CH_ANALOG_TWO] = i_analog_input_two;
  assign new_result[MRSR_CH_SUPPLY] = i_supply_result;
  assign new_result[MRSR_CH_FAR_ONE] = i_far_sensor_one_result;
  assign new_result[MRSR_CH_ONCHIP] = i_onchip_temp_result;

  // Read strobes that carry side effects
  assign rd_ext_one = i_rd_en && (i_rd_addr == MRSR_ADDR_EXT_ONE);
  assign rd_ext_two = i_rd_en && (i_rd_addr == MRSR_ADDR_EXT_TWO);
  assign rd_flags = i_rd_en && (i_rd_addr == MRSR_ADDR_EVENT_FLAGS);
  assign rd_timer = i_rd_en && (i_rd_addr == MRSR_ADDR_HOT_TIMER);

  // Pin is active low and asynchronous; only the second stage is used
  assign hot = !q.pin_sync2;

  // Cooler flags gated by the drive being on; limit flags follow the comparators
  assign events[MRSR_FLAG_COOLER_TWO] = i_second_cooler_slow && i_second_cooler_output_on; // R11
  assign events[MRSR_FLAG_COOLER_ONE] = i_first_cooler_slow && i_first_cooler_output_on; // R12
  assign events[MRSR_FLAG_ONCHIP] = i_onchip_temp_fault; // R13
  assign events[MRSR_FLAG_FAR_ONE] = i_far_sensor_one_fault; // R14
  assign events[MRSR_FLAG_SUPPLY] = i_supply_fault; // R15
  assign events[MRSR_FLAG_ANALOG_TWO] = i_analog_two_fault; // R15
  assign events[MRSR_FLAG_ANALOG_ONE] = i_analog_one_fault; // R15

  // Summary of the second status register, not latched here
  assign second_status_summary = |i_second_status; // R17

  // Read clears cooler bits always, limit bits only once the fault has gone
  always_comb begin
    clear_mask = 7'h00;
    if (rd_flags) begin
      clear_mask = (~MRSR_LIMIT_FLAG_MASK) | (MRSR_LIMIT_FLAG_MASK & ~events); // R16
    end
  end

  // Next state: sync, held readings, freeze tracking, flags and read data
  always_comb begin
    d = q;
    d.pin_sync1 = i_overheat_pin_n;
    d.pin_sync2 = q.pin_sync1;
    // Freeze starts on an extension read and is released per MSB read
    if (rd_ext_one) begin
      d.pend = q.pend | MRSR_PEND_VOLT_GROUP; // R04
    end
    if (rd_ext_two) begin
      d.pend = q.pend | MRSR_PEND_TEMP_GROUP; // R05
    end
    if (i_rd_en) begin
      if (i_rd_addr == MRSR_ADDR_ANALOG_ONE) begin
        d.pend[MRSR_CH_ANALOG_ONE] = 1'b0; // R04
      end
      if (i_rd_addr == MRSR_ADDR_ANALOG_TWO) begin
        d.pend[MRSR_CH_ANALOG_TWO] = 1'b0;
      end
      if (i_rd_addr == MRSR_ADDR_SUPPLY) begin
        d.pend[MRSR_CH_SUPPLY] = 1'b0;
      end
      if (i_rd_addr == MRSR_ADDR_FAR_ONE) begin
        d.pend[MRSR_CH_FAR_ONE] = 1'b0; // R04
      end
      if (i_rd_addr == MRSR_ADDR_ONCHIP) begin
        d.pend[MRSR_CH_ONCHIP] = 1'b0; // R05
      end
    end
    // A group refreshes only when none of its MSBs await a read, so the
    // extension bits and MSBs the host sees always come from one conversion.
    // This relies on the host reading the extension register first.
    if (i_result_valid) begin
      for (int ch = 0; ch < MRSR_NUM_CH; ch++) begin
        if (ch == MRSR_CH_ONCHIP) begin
          if (!q.pend[MRSR_CH_ONCHIP] && !rd_ext_two) begin
            d.held[ch] = new_result[ch]; // R05 R03
          end
        end else if (((q.pend & MRSR_PEND_VOLT_GROUP) == MRSR_PEND_RESET) && !rd_ext_one) begin
          d.held[ch] = new_result[ch]; // R04 R03
        end
      end
    end
    // Set wins over the read clear
    d.flags = (q.flags & ~clear_mask) | events; // R16
    d.rd_valid = i_rd_en;
    d.rd_data = MRSR_REG_RESET;
    if (i_rd_en) begin
      case (i_rd_addr)
        MRSR_ADDR_EXT_ONE: begin
          d.rd_data = {q.held[MRSR_CH_ANALOG_ONE][1:0], q.held[MRSR_CH_ANALOG_TWO][1:0],
                       q.held[MRSR_CH_SUPPLY][1:0], q.held[MRSR_CH_FAR_ONE][1:0]}; // R18
        end
        MRSR_ADDR_EXT_TWO: begin
          d.rd_data = {6'h00, q.held[MRSR_CH_ONCHIP][1:0]}; // R01 R02
        end
        MRSR_ADDR_ANALOG_ONE: begin
          d.rd_data = q.held[MRSR_CH_ANALOG_ONE][9:2]; // R06
        end
        MRSR_ADDR_ANALOG_TWO: begin
          d.rd_data = q.held[MRSR_CH_ANALOG_TWO][9:2]; // R06
        end
        MRSR_ADDR_SUPPLY: begin
          d.rd_data = q.held[MRSR_CH_SUPPLY][9:2]; // R06
        end
        MRSR_ADDR_FAR_ONE: begin
          d.rd_data = q.held[MRSR_CH_FAR_ONE][9:2]; // R07
        end
        MRSR_ADDR_ONCHIP: begin
          d.rd_data = q.held[MRSR_CH_ONCHIP][9:2]; // R07
        end
        MRSR_ADDR_HOT_TIMER: begin
          d.rd_data = timer_value; // R08
        end
        MRSR_ADDR_EVENT_FLAGS: begin
          d.rd_data = {second_status_summary, q.flags}; // R17
        end
        default: begin
          d.rd_data = MRSR_REG_RESET;
        end
      endcase
    end
  end

  // State register; readings reset to zero
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      q <= '0; // R07
      q.pin_sync1 <= 1'b1;
      q.pin_sync2 <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Hot assertion timer; a read of its register clears the flag, and clears the count only once hot has gone
  mrsr_hot_timer #(
    .TICK_CYCLES(HOT_TICK_CYCLES)
  ) u_timer (
    .i_clock(i_clock),
    .i_reset_n(i_reset_n),
    .i_hot(hot),
    .i_read(rd_timer),
    .o_value(timer_value)
  );

  assign o_rd_data = q.rd_data;
  assign o_rd_valid = q.rd_valid;

  AST_EXT_TWO_LOW: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R01
    rd_ext_two |=> (o_rd_data[1:0] == $past(q.held[MRSR_CH_ONCHIP][1:0])))
    else $error("onchip low bits wrong in second extension read");
  AST_EXT_TWO_UPPER: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R02
    rd_ext_two |=> (o_rd_data[7:2] == 6'h00))
    else $error("unused extension bits not zero");
  AST_VOLT_FROZEN: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R04
    (q.pend[MRSR_CH_SUPPLY] || rd_ext_one) |=> $stable(q.held[MRSR_CH_SUPPLY]))
    else $error("supply reading changed while frozen");
  AST_TEMP_FROZEN: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R05
    (q.pend[MRSR_CH_ONCHIP] || rd_ext_two) |=> $stable(q.held[MRSR_CH_ONCHIP]))
    else $error("onchip reading changed while frozen");
  AST_SUPPLY_MSB: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R06
    (i_rd_en && i_rd_addr == MRSR_ADDR_SUPPLY) |=> (o_rd_data == $past(q.held[MRSR_CH_SUPPLY][9:2])))
    else $error("supply MSB read wrong");
  AST_ONCHIP_MSB: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R07
    (i_rd_en && i_rd_addr == MRSR_ADDR_ONCHIP) |=> (o_rd_data == $past(q.held[MRSR_CH_ONCHIP][9:2])))
    else $error("onchip MSB read wrong");
  AST_COOLER_GATED: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R11
    (!q.flags[MRSR_FLAG_COOLER_TWO] && !i_second_cooler_output_on) |=> !q.flags[MRSR_FLAG_COOLER_TWO])
    else $error("cooler flag set with drive off");
  AST_LIMIT_STICKY: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R16
    (rd_flags && i_onchip_temp_fault) |=> q.flags[MRSR_FLAG_ONCHIP])
    else $error("limit flag cleared while fault present");
  AST_LIMIT_CLEARS: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R16
    (rd_flags && !i_far_sensor_one_fault) |=> !q.flags[MRSR_FLAG_FAR_ONE])
    else $error("limit flag kept after read with fault gone");
  AST_SUMMARY: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R17
    rd_flags |=> (o_rd_data[MRSR_FLAG_SUMMARY] == $past(|i_second_status)))
    else $error("summary bit does not match second status");
  AST_EXT_ONE_PAIRS: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R18
    rd_ext_one |=> (o_rd_data[1:0] == $past(q.held[MRSR_CH_FAR_ONE][1:0])) &&
      (o_rd_data[7:6] == $past(q.held[MRSR_CH_ANALOG_ONE][1:0])))
    else $error("first extension pairs misplaced");

  // Other MSB addresses, freeze of further channels, flag setting and read data
  AST_EXT_ONE_MID: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R18
    rd_ext_one |=> (o_rd_data[5:4] == $past(q.held[MRSR_CH_ANALOG_TWO][1:0])) &&
      (o_rd_data[3:2] == $past(q.held[MRSR_CH_SUPPLY][1:0])))
    else $error("first extension middle pairs misplaced");
  AST_ANALOG_ONE_MSB: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R06
    (i_rd_en && i_rd_addr == MRSR_ADDR_ANALOG_ONE) |=> (o_rd_data == $past(q.held[MRSR_CH_ANALOG_ONE][9:2])))
    else $error("analog one MSB read wrong");
  AST_ANALOG_TWO_MSB: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R06
    (i_rd_en && i_rd_addr == MRSR_ADDR_ANALOG_TWO) |=> (o_rd_data == $past(q.held[MRSR_CH_ANALOG_TWO][9:2])))
    else $error("analog two MSB read wrong");
  AST_FAR_MSB: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R07
    (i_rd_en && i_rd_addr == MRSR_ADDR_FAR_ONE) |=> (o_rd_data == $past(q.held[MRSR_CH_FAR_ONE][9:2])))
    else $error("far sensor MSB read wrong");
  AST_FAR_FROZEN: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R04
    (q.pend[MRSR_CH_FAR_ONE] || rd_ext_one) |=> $stable(q.held[MRSR_CH_FAR_ONE]))
    else $error("far sensor reading changed while frozen");
  AST_ANALOG_FROZEN: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R04
    (q.pend[MRSR_CH_ANALOG_ONE] || rd_ext_one) |=> $stable(q.held[MRSR_CH_ANALOG_ONE]))
    else $error("analog one reading changed while frozen");
  AST_COOLER_ONE_GATED: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R12
    (!q.flags[MRSR_FLAG_COOLER_ONE] && !i_first_cooler_output_on) |=> !q.flags[MRSR_FLAG_COOLER_ONE])
    else $error("first cooler flag set with drive off");
  AST_COOLER_TWO_SET: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R11
    (i_second_cooler_slow && i_second_cooler_output_on) |=> q.flags[MRSR_FLAG_COOLER_TWO])
    else $error("second cooler flag not set");
  AST_COOLER_ONE_SET: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R12
    (i_first_cooler_slow && i_first_cooler_output_on) |=> q.flags[MRSR_FLAG_COOLER_ONE])
    else $error("first cooler flag not set");
  AST_COOLER_CLEARS: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R11
    (rd_flags && !(i_second_cooler_slow && i_second_cooler_output_on)) |=> !q.flags[MRSR_FLAG_COOLER_TWO])
    else $error("second cooler flag kept after read");
  AST_ONCHIP_SET: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R13
    i_onchip_temp_fault |=> q.flags[MRSR_FLAG_ONCHIP])
    else $error("onchip limit flag not set");
  AST_FAR_SET: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R14
    i_far_sensor_one_fault |=> q.flags[MRSR_FLAG_FAR_ONE])
    else $error("far sensor limit flag not set");
  AST_SUPPLY_SET: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R15
    i_supply_fault |=> q.flags[MRSR_FLAG_SUPPLY])
    else $error("supply limit flag not set");
  AST_ANALOG_TWO_SET: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R15
    i_analog_two_fault |=> q.flags[MRSR_FLAG_ANALOG_TWO])
    else $error("analog two limit flag not set");
  AST_ANALOG_ONE_SET: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R15
    i_analog_one_fault |=> q.flags[MRSR_FLAG_ANALOG_ONE])
    else $error("analog one limit flag not set");
  AST_FLAGS_DATA: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R16
    rd_flags |=> (o_rd_data[6:0] == $past(q.flags)))
    else $error("event flags read does not show flags before clear");
  AST_TIMER_DATA: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R08
    rd_timer |=> (o_rd_data == $past(timer_value)))
    else $error("timer read does not show timer value");
  AST_RESULT_TAKEN: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R19
    (i_result_valid && (q.pend == MRSR_PEND_RESET) && !rd_ext_one) |=> (q.held[MRSR_CH_SUPPLY] == $past(i_supply_result)))
    else $error("free supply result not taken");
  AST_ONCHIP_TAKEN: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R19
    (i_result_valid && !q.pend[MRSR_CH_ONCHIP] && !rd_ext_two) |=> (q.held[MRSR_CH_ONCHIP] == $past(i_onchip_temp_result)))
    else $error("free onchip result not taken");
  COV_FREEZE_RELEASE: cover property (@(posedge i_clock) disable iff (!i_reset_n)
    rd_ext_one ##[1:20] (q.pend == MRSR_PEND_RESET));
  COV_STICKY_READ: cover property (@(posedge i_clock) disable iff (!i_reset_n)
    rd_flags && i_supply_fault);
  COV_TIMER_READ: cover property (@(posedge i_clock) disable iff (!i_reset_n)
    rd_timer && (timer_value != 8'h00));
endmodule

// ==== logic/mrsr_hot_timer.sv ====
// Hot assertion timer: assertion flag and duration count in 22.76 ms steps
`timescale 1ns/1ps
module mrsr_hot_timer #(
  parameter int TICK_CYCLES = mrsr_pkg::MRSR_TICK_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_hot,
  input wire logic i_read,
  output logic [7:0] o_value
);
  import mrsr_pkg::*;

  localparam logic [19:0] TICK_LAST = 20'(TICK_CYCLES - 1);

  mrsr_timer_state_t q;
  mrsr_timer_state_t d;
  logic hot_rise;

  assign hot_rise = i_hot && !q.hot_prev;

  // Next state of flag, duration and presented value
  always_comb begin
    d = q;
    d.hot_prev = i_hot;
    if (i_read) begin
      d.hot_assert_flag = 1'b0; // R08
      if (!i_hot) begin
        // Count kept while still asserting, otherwise a new read starts clean
        d.assert_duration_count = 8'h00;
        d.sub_count = MRSR_SUB_RESET;
      end
    end
    if (hot_rise) begin
      // Set placed after the read clear so a new assertion is never lost
      d.hot_assert_flag = 1'b1; // R08
      d.assert_duration_count = 8'h00;
      d.sub_count = MRSR_SUB_RESET;
    end else if (i_hot) begin
      if (q.sub_count == TICK_LAST) begin
        d.sub_count = MRSR_SUB_RESET;
        if (q.assert_duration_count != MRSR_TICKS_MAX) begin
          d.assert_duration_count = q.assert_duration_count + 8'h01; // R10
        end
      end else begin
        d.sub_count = q.sub_count + 20'h0_0001;
      end
    end
    // Short assertions show only the flag; long ones show the count
    if (d.assert_duration_count >= MRSR_LONG_TICKS) begin
      d.value = d.assert_duration_count; // R10
    end else begin
      d.value = {7'h00, d.hot_assert_flag}; // R09
    end
  end

  // State register
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_value = q.value;

  AST_HOT_FLAG_SET: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R08
    hot_rise |=> (o_value == 8'h01))
    else $error("hot flag not shown after assertion");
  AST_SHORT_UPPER_ZERO: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R09
    (q.assert_duration_count < MRSR_LONG_TICKS) |-> (o_value[7:1] == 7'h00))
    else $error("timer upper bits nonzero before long assertion");
  AST_LONG_COUNT: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R10
    (q.assert_duration_count >= MRSR_LONG_TICKS) |-> (o_value == q.assert_duration_count))
    else $error("timer value does not follow duration count");
  COV_HOT_RISE: cover property (@(posedge i_clock) disable iff (!i_reset_n) hot_rise);
endmodule

// ==== logic/mrsr_pkg.sv ====
// Package: addresses, channel layout, reset values and timing of the monitor readout registers
package mrsr_pkg;

  // Register addresses
  localparam logic [7:0] MRSR_ADDR_EXT_ONE = 8'h08;
  localparam logic [7:0] MRSR_ADDR_EXT_TWO = 8'h09;
  localparam logic [7:0] MRSR_ADDR_ANALOG_ONE = 8'h0A;
  localparam logic [7:0] MRSR_ADDR_ANALOG_TWO = 8'h0B;
  localparam logic [7:0] MRSR_ADDR_SUPPLY = 8'h0C;
  localparam logic [7:0] MRSR_ADDR_FAR_ONE = 8'h0D;
  localparam logic [7:0] MRSR_ADDR_ONCHIP = 8'h0E;
  localparam logic [7:0] MRSR_ADDR_HOT_TIMER = 8'h0F;
  localparam logic [7:0] MRSR_ADDR_EVENT_FLAGS = 8'h10;

  // Reading channels, index into the held reading array
  localparam int MRSR_NUM_CH = 5;
  localparam int MRSR_CH_ANALOG_ONE = 0;
  localparam int MRSR_CH_ANALOG_TWO = 1;
  localparam int MRSR_CH_SUPPLY = 2;
  localparam int MRSR_CH_FAR_ONE = 3;
  localparam int MRSR_CH_ONCHIP = 4;

  // Status bit positions in the first event flag register
  localparam int MRSR_FLAG_COOLER_TWO = 0;
  localparam int MRSR_FLAG_COOLER_ONE = 1;
  localparam int MRSR_FLAG_ONCHIP = 2;
  localparam int MRSR_FLAG_FAR_ONE = 3;
  localparam int MRSR_FLAG_SUPPLY = 4;
  localparam int MRSR_FLAG_ANALOG_TWO = 5;
  localparam int MRSR_FLAG_ANALOG_ONE = 6;
  localparam int MRSR_FLAG_SUMMARY = 7;
  localparam logic [6:0] MRSR_LIMIT_FLAG_MASK = 7'h7C;

  // Reset values and freeze group masks
  localparam logic [7:0] MRSR_REG_RESET = 8'h00;
  localparam logic [9:0] MRSR_READING_RESET = 10'h000;
  localparam logic [6:0] MRSR_FLAGS_RESET = 7'h00;
  localparam logic [4:0] MRSR_PEND_RESET = 5'h00;
  localparam logic [4:0] MRSR_PEND_VOLT_GROUP = 5'h0F;
  localparam logic [4:0] MRSR_PEND_TEMP_GROUP = 5'h10;

  // Timing of the hot assertion timer
  localparam int MRSR_CLK_PERIOD_NS = 25;
  localparam real MRSR_TICK_TIME_MS = 22.76;
  localparam real MRSR_LONG_TIME_MS = 45.52;
  localparam int MRSR_TICK_CYCLES = int'(MRSR_TICK_TIME_MS * 1.0e6 / MRSR_CLK_PERIOD_NS);
  localparam logic [7:0] MRSR_LONG_TICKS = 8'(int'(MRSR_LONG_TIME_MS / MRSR_TICK_TIME_MS));
  localparam logic [19:0] MRSR_SUB_RESET = 20'h0_0000;
  localparam logic [7:0] MRSR_TICKS_MAX = 8'hFF;

  // Timer state
  typedef struct packed {
    logic hot_prev;
    logic hot_assert_flag;
    logic [7:0] assert_duration_count;
    logic [19:0] sub_count;
    logic [7:0] value;
  } mrsr_timer_state_t;

  // Register bank state
  typedef struct packed {
    logic pin_sync1;
    logic pin_sync2;
    logic [MRSR_NUM_CH-1:0][9:0] held;
    logic [MRSR_NUM_CH-1:0] pend;
    logic [6:0] flags;
    logic [7:0] rd_data;
    logic rd_valid;
  } mrsr_bank_state_t;

endpackage

// ==== testbench/monitor_readout_status_regs_test.sv ====
// Testbench for the monitor readout bank: readings, freeze, event flags, hot timer
`timescale 1ns/1ps
module monitor_readout_status_regs_test;
  import mrsr_pkg::*;
  localparam int TICKS = 8; // Shortened tick so saturation fits the run
  logic i_clock = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_rd_en;
  logic [7:0] i_rd_addr;
  logic [7:0] o_rd_data;
  logic o_rd_valid;
  logic i_result_valid = 1'b0;
  logic [9:0] res [5] = '{default: 10'h000};
  logic [9:0] held [5] = '{default: 10'h000};
  logic [6:0] ev = 7'h00;
  logic [1:0] drv = 2'b00;
  logic [7:0] st = 8'h00;
  logic overheat_n = 1'b1;
  int bad_count = 0;
  int n_compared = 0;

  always #12.5 i_clock = ~i_clock;

  mrsr_host_model host_u (.i_clock(i_clock), .i_rd_data(o_rd_data), .i_rd_valid(o_rd_valid),
    .o_rd_en(i_rd_en), .o_rd_addr(i_rd_addr));

  mrsr_bank #(.HOT_TICK_CYCLES(TICKS)) dut_u (
    .i_clock(i_clock), .i_reset_n(i_reset_n), .i_rd_en(i_rd_en), .i_rd_addr(i_rd_addr),
    .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid), .i_result_valid(i_result_valid),
    .i_analog_input_one(res[0]), .i_analog_input_two(res[1]), .i_supply_result(res[2]),
    .i_far_sensor_one_result(res[3]), .i_onchip_temp_result(res[4]), .i_overheat_pin_n(overheat_n),
    .i_first_cooler_slow(ev[MRSR_FLAG_COOLER_ONE]), .i_second_cooler_slow(ev[MRSR_FLAG_COOLER_TWO]),
    .i_first_cooler_output_on(drv[1]), .i_second_cooler_output_on(drv[0]),
    .i_onchip_temp_fault(ev[MRSR_FLAG_ONCHIP]), .i_far_sensor_one_fault(ev[MRSR_FLAG_FAR_ONE]),
    .i_supply_fault(ev[MRSR_FLAG_SUPPLY]), .i_analog_two_fault(ev[MRSR_FLAG_ANALOG_TWO]),
    .i_analog_one_fault(ev[MRSR_FLAG_ANALOG_ONE]), .i_second_status(st));

  // Verdict and end of run, also reached from a timed-out read
  task automatic print_verdict();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Read through the host model and compare
  task automatic rd(input string what, input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    host_u.read_reg(addr, d, ok);
    if (!ok) begin
      bad_count++;
      $display("mismatch %s expected answer seen none", what);
      print_verdict();
    end else begin
      check(what, d, exp);
    end
  endtask

  // New results; a frozen group keeps its old values
  task automatic push(input bit acc_v, input bit acc_t);
    @(negedge i_clock);
    for (int k = 0; k < 5; k++) res[k] = 10'($urandom);
    i_result_valid = 1'b1;
    @(negedge i_clock);
    i_result_valid = 1'b0;
    for (int k = 0; k < 4; k++) if (acc_v) held[k] = res[k];
    if (acc_t) held[4] = res[4];
  endtask

  function automatic logic [7:0] ext_one();
    return {held[0][1:0], held[1][1:0], held[2][1:0], held[3][1:0]};
  endfunction

  initial begin
    void'($urandom(82740));
    repeat (5) @(negedge i_clock);
    i_reset_n = 1'b1;
    // Reset values, unmapped address included
    for (int a = 8; a <= 16; a++) rd("reset_value", 8'(a), MRSR_REG_RESET);
    rd("unmapped", 8'h20, 8'h00);
    $display("test reset done");
    // Readings, freeze and release of both groups
    for (int i = 0; i < 3; i++) begin
      push(1'b1, 1'b1);
      rd("ext_one", MRSR_ADDR_EXT_ONE, ext_one());
      push(1'b0, 1'b1);
      for (int k = 0; k < 4; k++) rd("msb_frozen", 8'(MRSR_ADDR_ANALOG_ONE + k), held[k][9:2]);
      push(1'b1, 1'b1);
      rd("supply_free", MRSR_ADDR_SUPPLY, held[MRSR_CH_SUPPLY][9:2]);
      rd("ext_two", MRSR_ADDR_EXT_TWO, {6'h00, held[4][1:0]});
      push(1'b1, 1'b0);
      rd("onchip_frozen", MRSR_ADDR_ONCHIP, held[4][9:2]);
      push(1'b1, 1'b1);
      rd("onchip_free", MRSR_ADDR_ONCHIP, held[4][9:2]);
      rd("far_free", MRSR_ADDR_FAR_ONE, held[3][9:2]);
    end
    $display("test readings done");
    // Each event bit: drive gating for the two cooler bits, sticky while present, clear after it goes
    for (int b = 0; b < 7; b++) begin
      @(negedge i_clock);
      drv = 2'b00;
      ev[b] = 1'b1;
      if (b < 2) rd("cooler_drive_off", MRSR_ADDR_EVENT_FLAGS, 8'h00);
      @(negedge i_clock);
      drv = 2'b11;
      rd("event_set", MRSR_ADDR_EVENT_FLAGS, 8'(1 << b));
      rd("event_present", MRSR_ADDR_EVENT_FLAGS, 8'(1 << b));
      @(negedge i_clock);
      ev[b] = 1'b0;
      rd("event_latched", MRSR_ADDR_EVENT_FLAGS, 8'(1 << b));
      rd("event_cleared", MRSR_ADDR_EVENT_FLAGS, 8'h00);
    end
    // Summary bit follows the second status contents
    for (int i = 0; i < 4; i++) begin
      @(negedge i_clock);
      st = (i == 3) ? 8'h00 : 8'($urandom);
      rd("summary", MRSR_ADDR_EVENT_FLAGS, {|st, 7'h00});
    end
    $display("test event flags done");
    // Overheat: flag, clear on read, saturated count, clear after release
    @(negedge i_clock);
    overheat_n = 1'b0;
    repeat (6) @(negedge i_clock);
    rd("hot_flag", MRSR_ADDR_HOT_TIMER, 8'h01);
    rd("hot_flag_read", MRSR_ADDR_HOT_TIMER, 8'h00);
    repeat (2100) @(negedge i_clock);
    rd("hot_count_sat", MRSR_ADDR_HOT_TIMER, MRSR_TICKS_MAX);
    overheat_n = 1'b1;
    repeat (4) @(negedge i_clock);
    rd("hot_count_kept", MRSR_ADDR_HOT_TIMER, MRSR_TICKS_MAX);
    rd("hot_count_clear", MRSR_ADDR_HOT_TIMER, 8'h00);
    $display("test hot timer done");
    print_verdict();
  end
endmodule

// ==== testbench/mrsr_host_model.sv ====
// Host model: reads the monitor registers one request at a time
`timescale 1ns/1ps
module mrsr_host_model (
  input wire logic i_clock,
  input wire logic [7:0] i_rd_data,
  input wire logic i_rd_valid,
  output logic o_rd_en,
  output logic [7:0] o_rd_addr
);
  // Idle request at time zero
  initial begin
    o_rd_en = 1'b0;
    o_rd_addr = 8'h00;
  end

  // One read: request for one edge, answer within a bounded wait
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data, output logic ok);
    int n;
    ok = 1'b0;
    data = 8'h00;
    @(negedge i_clock);
    o_rd_en = 1'b1;
    o_rd_addr = addr;
    @(negedge i_clock);
    o_rd_en = 1'b0;
    o_rd_addr = ~addr; // Not held after the request: a changing pattern, not a stale value
    // Answer stands only in the cycle after the taking edge, so look at it mid-cycle
    for (n = 0; n < 4 && !ok; n++) begin
      if (i_rd_valid === 1'b1) begin
        ok = 1'b1;
        data = i_rd_data;
      end else begin
        @(negedge i_clock);
      end
    end
  endtask
endmodule
